//--- rbtfo_core.sv
// wishbone-reached slice: rotates through carry, transfer-bit moves, S flag
// Function
// - rotate left: bit0 gets carry, carry gets bit7
// - rotate right: bit7 gets carry, carry gets bit0
// - bit store copies source bit into T
// - bit load writes T into destination bit
// - set signed flag forces S to one
// - clear signed flag forces S to zero
`timescale 1ns/1ps
module rbtfo_core #(
    parameter int NREG  = rbtfo_pkg::NREG_DEF,
    parameter int ADR_W = 8
) (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [ADR_W-1:0]            wb_adr_i,
    input  wire logic [rbtfo_pkg::WB_SW-1:0] wb_sel_i,
    input  wire logic [rbtfo_pkg::WB_DW-1:0] wb_dat_i,
    output logic      [rbtfo_pkg::WB_DW-1:0] wb_dat_o,
    output logic                             wb_ack_o,
    output logic      [7:0]                  status_o
);

    localparam int RIDX_W = $clog2(NREG);
    localparam int DW     = rbtfo_pkg::DATA_W;

    generate
        if (NREG < 2 || NREG > 256 || (1 << RIDX_W) != NREG || ADR_W < 5)
        begin : g_bad_param
            $error("register count or address width out of range");
        end
    endgenerate
    function automatic logic hit(input logic [ADR_W-1:0] adr,
                                 input logic [7:0]       off);
        hit = (adr == ADR_W'(off));
    endfunction : hit

    // flag update shared by both rotates: Z, N, C, V from result and carry
    function automatic logic [7:0] rot_flags(input logic [7:0]    st,
                                             input logic [DW-1:0] res,
                                             input logic          c);
        logic [7:0] f;
        f = st;
        f[rbtfo_pkg::FLAG_C] = c;
        f[rbtfo_pkg::FLAG_Z] = (res == '0);
        f[rbtfo_pkg::FLAG_N] = res[DW-1];
        f[rbtfo_pkg::FLAG_V] = res[DW-1] ^ c;
        rot_flags = f;
    endfunction : rot_flags

    rbtfo_pkg::rbtfo_state_t state_reg;
    rbtfo_pkg::rbtfo_state_t state_next;
    logic [rbtfo_pkg::CMD_W-1:0] cmd_reg;
    logic [rbtfo_pkg::CMD_W-1:0] cmd_next;
    logic [7:0]                  status_reg;
    logic [7:0]                  status_next;
    logic [RIDX_W-1:0]           dest_sel_reg;
    logic [RIDX_W-1:0]           dest_sel_next;
    logic [RIDX_W-1:0]           src_sel_reg;
    logic [RIDX_W-1:0]           src_sel_next;
    logic                        ack_reg;
    logic                        ack_next;
    logic [rbtfo_pkg::WB_DW-1:0] dat_reg;
    logic [rbtfo_pkg::WB_DW-1:0] dat_next;
    logic              mem_we;
    logic [RIDX_W-1:0] mem_waddr;
    logic [DW-1:0]     mem_wdata;
    logic [RIDX_W-1:0] mem_raddr;
    logic [DW-1:0]     mem_rdata;
    rbtfo_pkg::rbtfo_op_t  cur_op;
    rbtfo_pkg::rbtfo_op_t  new_op;
    logic [2:0]            cur_bit;
    logic                  req;
    logic                  wr_lane;
    assign cur_op  = rbtfo_pkg::rbtfo_op_t'(
        cmd_reg[rbtfo_pkg::CMD_OP_LSB +: rbtfo_pkg::CMD_OP_W]);
    assign new_op  = rbtfo_pkg::rbtfo_op_t'(
        wb_dat_i[rbtfo_pkg::CMD_OP_LSB +: rbtfo_pkg::CMD_OP_W]);
    assign cur_bit = cmd_reg[rbtfo_pkg::CMD_BIT_LSB +: rbtfo_pkg::CMD_BIT_W];
    // ack_reg gate keeps a still-held strobe from starting a second access
    assign req     = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_lane = wb_we_i && wb_sel_i[0];
    rbtfo_regfile #(
        .DEPTH (NREG),
        .WIDTH (DW),
        .AW    (RIDX_W)
    ) u_regfile (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (mem_wdata),
        .raddr_i (mem_raddr),
        .rdata_o (mem_rdata)
    );
    always_comb
    begin
        logic [DW-1:0] res;
        res           = mem_rdata;
        state_next    = state_reg;
        cmd_next      = cmd_reg;
        status_next   = status_reg;
        dest_sel_next = dest_sel_reg;
        src_sel_next  = src_sel_reg;
        ack_next      = 1'b0;
        dat_next      = dat_reg;
        mem_we        = 1'b0;
        mem_waddr     = dest_sel_reg;
        mem_wdata     = wb_dat_i[DW-1:0];
        mem_raddr     = dest_sel_reg;
        case (state_reg)
            rbtfo_pkg::ST_IDLE:
            begin
                if (req && wr_lane && hit(wb_adr_i, rbtfo_pkg::OFF_CMD))
                begin
                    cmd_next = wb_dat_i[rbtfo_pkg::CMD_W-1:0];
                    case (new_op)
                        rbtfo_pkg::SET_SIGNED_FLAG_OP:
                        begin
                            status_next[rbtfo_pkg::FLAG_S] = 1'b1;
                            ack_next = 1'b1;
                        end
                        rbtfo_pkg::CLEAR_SIGNED_FLAG_OP:
                        begin
                            status_next[rbtfo_pkg::FLAG_S] = 1'b0;
                            ack_next = 1'b1;
                        end
                        rbtfo_pkg::NOP_OP:
                        begin
                            ack_next = 1'b1;
                        end
                        rbtfo_pkg::BIT_STORE_TO_TRANSFER_OP:
                        begin
                            mem_raddr  = src_sel_reg;
                            state_next = rbtfo_pkg::ST_EXEC;
                        end
                        default:
                        begin
                            state_next = rbtfo_pkg::ST_EXEC;
                        end
                    endcase
                end
                else if (req && wr_lane)
                begin
                    ack_next = 1'b1;
                    if (hit(wb_adr_i, rbtfo_pkg::OFF_STATUS))
                    begin
                        status_next = wb_dat_i[7:0];
                    end
                    if (hit(wb_adr_i, rbtfo_pkg::OFF_DEST_SEL))
                    begin
                        dest_sel_next = wb_dat_i[RIDX_W-1:0];
                    end
                    if (hit(wb_adr_i, rbtfo_pkg::OFF_SRC_SEL))
                    begin
                        src_sel_next = wb_dat_i[RIDX_W-1:0];
                    end
                    if (hit(wb_adr_i, rbtfo_pkg::OFF_REG_DATA))
                    begin
                        mem_we = 1'b1;
                    end
                end
                else if (req && wb_we_i)
                begin
                    ack_next = 1'b1;
                end
                else if (req && hit(wb_adr_i, rbtfo_pkg::OFF_REG_DATA))
                begin
                    state_next = rbtfo_pkg::ST_RDWAIT;
                end
                else if (req)
                begin
                    ack_next = 1'b1;
                    dat_next = '0;
                    if (hit(wb_adr_i, rbtfo_pkg::OFF_CMD))
                    begin
                        dat_next[rbtfo_pkg::CMD_W-1:0] = cmd_reg;
                    end
                    if (hit(wb_adr_i, rbtfo_pkg::OFF_STATUS))
                    begin
                        dat_next[7:0] = status_reg;
                    end
                    if (hit(wb_adr_i, rbtfo_pkg::OFF_DEST_SEL))
                    begin
                        dat_next[RIDX_W-1:0] = dest_sel_reg;
                    end
                    if (hit(wb_adr_i, rbtfo_pkg::OFF_SRC_SEL))
                    begin
                        dat_next[RIDX_W-1:0] = src_sel_reg;
                    end
                end
            end
            rbtfo_pkg::ST_EXEC:
            begin
                ack_next   = 1'b1;
                state_next = rbtfo_pkg::ST_IDLE;
                case (cur_op)
                    rbtfo_pkg::ROTATE_LEFT_CARRY_OP:
                    begin
                        res = {mem_rdata[DW-2:0],
                               status_reg[rbtfo_pkg::FLAG_C]};
                        status_next = rot_flags(status_reg, res,
                                                mem_rdata[DW-1]);
                        mem_we = 1'b1;
                    end
                    rbtfo_pkg::ROTATE_RIGHT_CARRY_OP:
                    begin
                        res = {status_reg[rbtfo_pkg::FLAG_C],
                               mem_rdata[DW-1:1]};
                        status_next = rot_flags(status_reg, res,
                                                mem_rdata[0]);
                        mem_we = 1'b1;
                    end
                    rbtfo_pkg::BIT_STORE_TO_TRANSFER_OP:
                    begin
                        status_next[rbtfo_pkg::FLAG_T] =
                            mem_rdata[cur_bit];
                    end
                    rbtfo_pkg::BIT_LOAD_FROM_TRANSFER_OP:
                    begin
                        res[cur_bit] = status_reg[rbtfo_pkg::FLAG_T];
                        mem_we = 1'b1;
                    end
                    rbtfo_pkg::NIBBLE_SWAP_OP:
                    begin
                        res = {mem_rdata[3:0], mem_rdata[7:4]};
                        mem_we = 1'b1;
                    end
                    default:
                    begin
                        res = mem_rdata;
                    end
                endcase
                mem_wdata = res;
            end
            rbtfo_pkg::ST_RDWAIT:
            begin
                ack_next   = 1'b1;
                dat_next   = '0;
                dat_next[DW-1:0] = mem_rdata;
                state_next = rbtfo_pkg::ST_IDLE;
            end
            default:
            begin
                state_next = rbtfo_pkg::ST_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg    <= rbtfo_pkg::ST_IDLE;
            cmd_reg      <= '0;
            status_reg   <= rbtfo_pkg::STATUS_RST;
            dest_sel_reg <= '0;
            src_sel_reg  <= '0;
            ack_reg      <= 1'b0;
            dat_reg      <= '0;
        end
        else
        begin
            state_reg    <= state_next;
            cmd_reg      <= cmd_next;
            status_reg   <= status_next;
            dest_sel_reg <= dest_sel_next;
            src_sel_reg  <= src_sel_next;
            ack_reg      <= ack_next;
            dat_reg      <= dat_next;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign status_o = status_reg;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic in_exec;
    logic cmd_take;
    assign in_exec  = (state_reg == rbtfo_pkg::ST_EXEC);
    assign cmd_take = (state_reg == rbtfo_pkg::ST_IDLE) && req && wr_lane
                      && hit(wb_adr_i, rbtfo_pkg::OFF_CMD);
    rotl_result_a: assert property (
        in_exec && cur_op == rbtfo_pkg::ROTATE_LEFT_CARRY_OP
        |=> status_reg[rbtfo_pkg::FLAG_C] == $past(mem_rdata[7])
            && $past(mem_wdata) == {$past(mem_rdata[6:0]),
                                    $past(status_reg[rbtfo_pkg::FLAG_C])}
            && status_reg[7:4] == $past(status_reg[7:4]) && wb_ack_o)
        else $error("rotate left result or flags wrong");
    rotr_result_a: assert property (
        in_exec && cur_op == rbtfo_pkg::ROTATE_RIGHT_CARRY_OP
        |=> status_reg[rbtfo_pkg::FLAG_C] == $past(mem_rdata[0])
            && status_reg[rbtfo_pkg::FLAG_N] ==
               $past(status_reg[rbtfo_pkg::FLAG_C])
            && $past(mem_we) && wb_ack_o)
        else $error("rotate right result or flags wrong");
    tstore_copy_a: assert property (
        in_exec && cur_op == rbtfo_pkg::BIT_STORE_TO_TRANSFER_OP
        |=> status_reg[rbtfo_pkg::FLAG_T] == $past(mem_rdata[cur_bit])
            && status_reg[5:0] == $past(status_reg[5:0])
            && status_reg[7] == $past(status_reg[7])
            && !$past(mem_we))
        else $error("bit store changed more than the transfer flag");
    tload_bit_a: assert property (
        in_exec && cur_op == rbtfo_pkg::BIT_LOAD_FROM_TRANSFER_OP
        |-> mem_we && mem_wdata[cur_bit] == status_reg[rbtfo_pkg::FLAG_T]
            ##1 $stable(status_reg))
        else $error("bit load wrong bit or flags disturbed");
    sflag_set_a: assert property (
        cmd_take && new_op == rbtfo_pkg::SET_SIGNED_FLAG_OP
        |=> status_reg == ($past(status_reg) | 8'h10) && wb_ack_o)
        else $error("set signed flag wrong");
    sflag_clear_a: assert property (
        cmd_take && new_op == rbtfo_pkg::CLEAR_SIGNED_FLAG_OP
        |=> status_reg == ($past(status_reg) & 8'hEF) && wb_ack_o)
        else $error("clear signed flag wrong");
    swap_nibble_a: assert property (
        in_exec && cur_op == rbtfo_pkg::NIBBLE_SWAP_OP
        |-> mem_wdata == {mem_rdata[3:0], mem_rdata[7:4]}
            ##1 $stable(status_reg) && wb_ack_o)
        else $error("nibble swap wrong");
    exec_done_a: assert property (
        cmd_take && new_op != rbtfo_pkg::NOP_OP
        |-> ##[1:2] wb_ack_o)
        else $error("operation took too long");
    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    rotl_seen_c: cover property (
        in_exec && cur_op == rbtfo_pkg::ROTATE_LEFT_CARRY_OP);
    store_load_c: cover property (
        in_exec && cur_op == rbtfo_pkg::BIT_STORE_TO_TRANSFER_OP
        ##[1:20] in_exec && cur_op == rbtfo_pkg::BIT_LOAD_FROM_TRANSFER_OP);
    sflag_seen_c: cover property (
        cmd_take && new_op == rbtfo_pkg::SET_SIGNED_FLAG_OP);
    data_read_c: cover property (state_reg == rbtfo_pkg::ST_RDWAIT);
endmodule : rbtfo_core

//--- rbtfo_host_model.sv
// wishbone master standing in for the decoder side of the slice
`timescale 1ns/1ps
module rbtfo_host_model (
    input  wire logic                        clk_i,
    input  wire logic                        ack_i,
    input  wire logic [rbtfo_pkg::WB_DW-1:0] dat_i,
    output logic                             cyc_o,
    output logic                             stb_o,
    output logic                             we_o,
    output logic      [7:0]                  adr_o,
    output logic      [rbtfo_pkg::WB_SW-1:0] sel_o,
    output logic      [rbtfo_pkg::WB_DW-1:0] dat_o
);
    initial
    begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0000_0000;
    end

    // one classic cycle; request held until the edge that samples ack
    task automatic xfer(input logic we, input logic [7:0] adr,
                        input logic [3:0] sel, input logic [7:0] wd,
                        output logic [7:0] rd, output logic hung);
        int n;
        hung = 1'b1;
        rd   = 8'h00;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= we;
        adr_o <= adr;
        sel_o <= sel;
        dat_o <= {24'h00_0000, wd};
        for (n = 0; n < 16; n++)
        begin
            @(posedge clk_i);
            if (ack_i === 1'b1)
            begin
                rd   = dat_i[7:0];
                hung = 1'b0;
                break;
            end
        end
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // released data must not keep showing the last write value
        dat_o <= ~dat_o;
    endtask : xfer
endmodule : rbtfo_host_model

//--- rbtfo_pkg.sv
// constants, opcodes and states of the rotate and bit-transfer slice
package rbtfo_pkg;

    // register word offsets (byte addresses on the wishbone port)
    localparam logic [7:0] OFF_CMD      = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_DEST_SEL = 8'h08;
    localparam logic [7:0] OFF_SRC_SEL  = 8'h0C;
    localparam logic [7:0] OFF_REG_DATA = 8'h10;

    // command word layout
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_OP_W    = 3;
    localparam int CMD_BIT_LSB = 3;
    localparam int CMD_BIT_W   = 3;
    localparam int CMD_W       = 6;

    // status register bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam int         DATA_W     = 8;
    localparam int         NREG_DEF   = 32;
    localparam int         WB_DW      = 32;
    localparam int         WB_SW      = 4;

    typedef enum logic [2:0] {
        NOP_OP                    = 3'h0,
        ROTATE_LEFT_CARRY_OP      = 3'h1,
        ROTATE_RIGHT_CARRY_OP     = 3'h2,
        BIT_STORE_TO_TRANSFER_OP  = 3'h3,
        BIT_LOAD_FROM_TRANSFER_OP = 3'h4,
        SET_SIGNED_FLAG_OP        = 3'h5,
        CLEAR_SIGNED_FLAG_OP      = 3'h6,
        NIBBLE_SWAP_OP            = 3'h7
    } rbtfo_op_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_EXEC   = 2'h1,
        ST_RDWAIT = 2'h2
    } rbtfo_state_t;

endpackage : rbtfo_pkg

//--- rbtfo_regfile.sv
// working register file, one write port, registered read port
`timescale 1ns/1ps
module rbtfo_regfile #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 8,
    parameter int AW    = 5
) (
    input  wire logic             clk_i,
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [WIDTH-1:0] rdata_o
);

    logic [WIDTH-1:0] mem_reg [DEPTH];

    generate
        if (DEPTH != (1 << AW))
        begin : g_bad_depth
            $error("regfile depth must equal two to the address width");
        end
    endgenerate

    // no reset on the array: contents are undefined until software loads them
    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_reg[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_reg[raddr_i];
    end

endmodule : rbtfo_regfile

//--- rotate_bit_transfer_flag_ops_tb.sv
// self-checking bench for the rotate and bit-transfer slice
`timescale 1ns/1ps
module rotate_bit_transfer_flag_ops_tb;
    localparam int FC = rbtfo_pkg::FLAG_C;
    localparam int FZ = rbtfo_pkg::FLAG_Z;
    localparam int FN = rbtfo_pkg::FLAG_N;
    localparam int FV = rbtfo_pkg::FLAG_V;
    localparam int FS = rbtfo_pkg::FLAG_S;
    localparam int FT = rbtfo_pkg::FLAG_T;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we, ack;
    logic [7:0]  adr, status, rd_v, sh_st;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, rnd;
    logic [7:0]  sh_reg [32];
    int          num_errors = 0;
    int          total_checks = 0;
    int          seed = 32'h3e3ca53f;

    always #20 clk_i = ~clk_i;

    rbtfo_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
        .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
        .dat_o(wdat));

    rbtfo_core #(.NREG(32), .ADR_W(8)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .status_o(status));

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [3:0] s, input logic [7:0] d);
        logic hung;
        host.xfer(w, a, s, d, rd_v, hung);
        if (hung)
        begin
            num_errors++;
            $display("[ERR] ack expected 1 seen 0");
            close_out();
        end
    endtask : bus

    task automatic set_status(input logic [7:0] v);
        bus(1'b1, rbtfo_pkg::OFF_STATUS, 4'hF, v);
        sh_st = v;
    endtask : set_status

    task automatic set_reg(input int d, input logic [7:0] v);
        bus(1'b1, rbtfo_pkg::OFF_DEST_SEL, 4'hF, d[7:0]);
        bus(1'b1, rbtfo_pkg::OFF_REG_DATA, 4'hF, v);
        sh_reg[d] = v;
    endtask : set_reg

    // expected effect of one command on the shadow registers and flags
    function automatic void apply(input logic [2:0] op, input int b,
                                  input int d, input int s);
        logic [7:0] r;
        logic       c;
        r = sh_reg[d];
        c = sh_st[FC];
        case (op)
            rbtfo_pkg::ROTATE_LEFT_CARRY_OP:      {c, r} = {r, c};
            rbtfo_pkg::ROTATE_RIGHT_CARRY_OP:     {r, c} = {c, r};
            rbtfo_pkg::BIT_STORE_TO_TRANSFER_OP:  sh_st[FT] = sh_reg[s][b];
            rbtfo_pkg::BIT_LOAD_FROM_TRANSFER_OP: r[b] = sh_st[FT];
            rbtfo_pkg::SET_SIGNED_FLAG_OP:        sh_st[FS] = 1'b1;
            rbtfo_pkg::CLEAR_SIGNED_FLAG_OP:      sh_st[FS] = 1'b0;
            rbtfo_pkg::NIBBLE_SWAP_OP:            r = {r[3:0], r[7:4]};
            default:                              r = sh_reg[d];
        endcase
        if (op == 3'h1 || op == 3'h2)
        begin
            sh_st[FC] = c;
            sh_st[FZ] = (r == 8'h00);
            sh_st[FN] = r[7];
            sh_st[FV] = r[7] ^ c;
        end
        sh_reg[d] = r;
    endfunction : apply

    // status is checked at the ack edge, so a late update is caught
    task automatic do_op(input logic [2:0] op, input int b,
                         input int d, input int s);
        bus(1'b1, rbtfo_pkg::OFF_DEST_SEL, 4'hF, d[7:0]);
        bus(1'b1, rbtfo_pkg::OFF_SRC_SEL, 4'hF, s[7:0]);
        bus(1'b1, rbtfo_pkg::OFF_CMD, 4'hF, {2'b00, b[2:0], op});
        apply(op, b, d, s);
        check("status", status, sh_st);
        bus(1'b0, rbtfo_pkg::OFF_REG_DATA, 4'hF, 8'h00);
        check("dest reg", rd_v, sh_reg[d]);
    endtask : do_op

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        check("reset status", status, rbtfo_pkg::STATUS_RST);
        sh_st = rbtfo_pkg::STATUS_RST;
        for (int i = 0; i < 32; i++)
            set_reg(i, 8'($random(seed)));
        // a lone top bit rotated out left, or a lone bottom bit rotated out right, leaves zero with carry and overflow
        set_status(8'h00);
        set_reg(3, 8'h80);
        do_op(3'h1, 0, 3, 0);
        check("rotate left flags", status, 8'h0B);
        set_status(8'h00);
        set_reg(3, 8'h01);
        do_op(3'h2, 0, 3, 0);
        check("rotate right flags", status, 8'h0B);
        set_status(8'hFF);
        do_op(3'h6, 7, 5, 5);
        check("clear signed", status, 8'hEF);
        do_op(3'h5, 0, 5, 5);
        check("set signed", status, 8'hFF);
        // mid-run reset clears flags and selects, keeps the register file
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        check("mid reset status", status, rbtfo_pkg::STATUS_RST);
        sh_st = rbtfo_pkg::STATUS_RST;
        bus(1'b0, rbtfo_pkg::OFF_DEST_SEL, 4'hF, 8'h00);
        check("mid reset dest sel", rd_v, 8'h00);
        for (int op = 0; op < 8; op++)
            do_op(op[2:0], 7 - op, op, 31 - op);
        // unmapped place and a write with lane 0 disabled change nothing
        bus(1'b0, 8'h14, 4'hF, 8'h00);
        check("unmapped read", rd_v, 8'h00);
        bus(1'b1, 8'h14, 4'hF, 8'h55);
        bus(1'b1, rbtfo_pkg::OFF_STATUS, 4'h0, ~sh_st);
        bus(1'b0, rbtfo_pkg::OFF_STATUS, 4'hF, 8'h00);
        check("status readback", rd_v, sh_st);
        for (int k = 0; k < 300; k++)
        begin
            rnd = $random(seed);
            if (rnd[31:30] == 2'b00)
                set_status(rnd[23:16]);
            do_op(rnd[2:0], int'(rnd[5:3]), int'(rnd[10:6]),
                  int'(rnd[15:11]));
        end
        close_out();
    end
endmodule : rotate_bit_transfer_flag_ops_tb
